// ---- card_model.sv ----
// card model driving the socket status pins
`timescale 1ns/1ps
module card_model (
	// card state
	input  wire logic       inserted,
	input  wire logic [1:0] batt_pins,
	// socket pins
	output logic            card_sense_one,
	output logic            card_sense_two,
	output logic            battery_detect_one,
	output logic            battery_detect_two
);
	// empty socket pins sit at their pull-up; a card grounds both sense pins
	assign card_sense_one     = !inserted;
	assign card_sense_two     = !inserted;
	// pin one also carries status change or bell flag, active low
	assign battery_detect_one = inserted ? batt_pins[0] : 1'h1;
	assign battery_detect_two = inserted ? batt_pins[1] : 1'h1;
endmodule : card_model

// ---- card_sense_pkg.sv ----
// constants shared by the socket status sense logic
package card_sense_pkg;
	localparam int          SYNC_STAGES   = 2;
	localparam logic [1:0]  PINS_RESET    = 2'h3; // pins idle high (pulled up)
	localparam logic [1:0]  BATT_GOOD     = 2'h0;
	localparam logic [1:0]  BATT_WEAK     = 2'h1;
	localparam logic [1:0]  BATT_DEAD     = 2'h2;
	localparam logic [3:0]  STATUS_RESET  = 4'h0;
	localparam logic        FLAG_RESET    = 1'h0; // single-bit flags clear after reset
	localparam int          EV_BATT_DEAD  = 0;
	localparam int          EV_BATT_WEAK  = 1;
	localparam int          EV_DETECT     = 2;
	localparam int          EV_STSC       = 3;

	typedef enum logic [1:0] {
		MODE_MEMORY = 2'h1,
		MODE_IO     = 2'h2
	} card_mode_e;
endpackage : card_sense_pkg

// ---- card_socket_status_sense.sv ----
// socket status pin sensing: card detect, battery decode, status change and ring
`timescale 1ns/1ps

// Notes on behaviour
// RULE_01: memory card: both battery pins high good, second low weak, first low dead.
// RULE_02: per-condition enables raise interrupt; changes latched in sticky change bits.
// RULE_03: io card: first battery pin low is card status change, forwarded as alert.
// RULE_04: modem card: first battery pin low signals ring, reported as ring indication.
// RULE_05: card present only when both card sense pins read low.
// RULE_06: live levels of sense and battery pins readable as interface status.
// RULE_07: every status pin passes two flip-flops before any decode or edge logic.
module card_socket_status_sense
	import card_sense_pkg::*;
(
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// card pins
	input  wire logic       card_sense_one,
	input  wire logic       card_sense_two,
	input  wire logic       battery_detect_one,
	input  wire logic       battery_detect_two,
	// software control
	input  wire logic       io_card_mode,
	input  wire logic [3:0] change_enable,
	input  wire logic [3:0] change_clear,
	// software-visible status
	output logic      [3:0] iface_status,
	output logic            card_present,
	output logic      [1:0] battery_state,
	output logic      [3:0] change_status,
	output logic            change_irq,
	output logic            system_alert,
	output logic            ring_indicate
);

	logic [3:0] meta_q, meta_d;
	logic [3:0] sync_q, sync_d;
	logic [3:0] prev_q, prev_d;
	logic [3:0] status_q, status_d;
	logic       present_q, present_d;
	logic [1:0] batt_q, batt_d;
	logic       irq_q, irq_d;
	logic       alert_q, alert_d;
	logic       ring_q, ring_d;
	logic [3:0] cond;
	logic [3:0] prev_cond;
	logic [3:0] events;
	card_mode_e mode;

	// decode the battery pins of a memory card
	function automatic logic [1:0] batt_decode(input logic b1, input logic b2);
		if (!b1) begin
			batt_decode = BATT_DEAD;
		end else if (!b2) begin
			batt_decode = BATT_WEAK;
		end else begin
			batt_decode = BATT_GOOD;
		end
	endfunction : batt_decode

	// map pin levels to event conditions {card_status_change, detect, weak, dead}
	function automatic logic [3:0] conditions(input logic [3:0] p, input card_mode_e m);
		logic [1:0] b;
		b = batt_decode(p[2], p[3]);
		conditions[EV_BATT_DEAD] = (m == MODE_MEMORY) && (b == BATT_DEAD);
		conditions[EV_BATT_WEAK] = (m == MODE_MEMORY) && (b == BATT_WEAK);
		conditions[EV_DETECT]    = !p[0] && !p[1];
		conditions[EV_STSC]      = (m == MODE_IO) && !p[2];
	endfunction : conditions

	// next-state logic
	always_comb begin
		mode      = io_card_mode ? MODE_IO : MODE_MEMORY;
		meta_d    = {battery_detect_two, battery_detect_one, card_sense_two, card_sense_one};
		sync_d    = meta_q; // see RULE_07
		prev_d    = sync_q;
		cond      = conditions(sync_q, mode);
		prev_cond = conditions(prev_q, mode);
		events    = cond ^ prev_cond; // see RULE_02
		status_d  = (status_q & ~change_clear) | (events & change_enable); // set wins, see RULE_02
		irq_d     = |(status_d & change_enable); // see RULE_02
		present_d = !sync_q[0] && !sync_q[1]; // see RULE_05
		batt_d    = batt_decode(sync_q[2], sync_q[3]); // see RULE_01
		alert_d   = (mode == MODE_IO) && !sync_q[2]; // see RULE_03
		ring_d    = (mode == MODE_IO) && !sync_q[2]; // see RULE_04
	end

	// registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q    <= {PINS_RESET, PINS_RESET};
			sync_q    <= {PINS_RESET, PINS_RESET};
			prev_q    <= {PINS_RESET, PINS_RESET};
			status_q  <= STATUS_RESET;
			present_q <= FLAG_RESET;
			batt_q    <= BATT_GOOD;
			irq_q     <= FLAG_RESET;
			alert_q   <= FLAG_RESET;
			ring_q    <= FLAG_RESET;
		end else begin
			meta_q    <= meta_d;
			sync_q    <= sync_d;
			prev_q    <= prev_d;
			status_q  <= status_d;
			present_q <= present_d;
			batt_q    <= batt_d;
			irq_q     <= irq_d;
			alert_q   <= alert_d;
			ring_q    <= ring_d;
		end
	end

	// outputs straight from flip-flops
	assign iface_status  = prev_q; // see RULE_06
	assign card_present  = present_q;
	assign battery_state = batt_q;
	assign change_status = status_q;
	assign change_irq    = irq_q;
	assign system_alert  = alert_q;
	assign ring_indicate = ring_q;

	// checks

	// presence follows the synchronised sense pins one edge later
	a_card_present_decode: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_05
		card_present == (!$past(sync_q[0]) && !$past(sync_q[1])))
		else $error("card present does not follow sense pins");

	// second sense pin still high never reports a card
	a_present_needs_both: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_05
		$past(sync_q[1]) |-> !card_present)
		else $error("card present with one sense pin high");

	// first battery pin low always reads as dead
	a_batt_dead_decode: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_01
		!$past(sync_q[2]) |-> battery_state == BATT_DEAD)
		else $error("dead battery not reported");

	// second pin low with first high reads as weak
	a_batt_weak_decode: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_01
		($past(sync_q[2]) && !$past(sync_q[3])) |-> battery_state == BATT_WEAK)
		else $error("weak battery not reported");

	// both pins high read as good
	a_batt_good_decode: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_01
		($past(sync_q[2]) && $past(sync_q[3])) |-> battery_state == BATT_GOOD)
		else $error("good battery not reported");

	// a pin held low over three edges has crossed both stages
	sequence s_pin_low_seen;
		!battery_detect_one ##1 !battery_detect_one ##1 !battery_detect_one;
	endsequence

	sequence s_sense_low_seen;
		!card_sense_one ##1 !card_sense_one ##1 !card_sense_one;
	endsequence

	sequence s_batt_two_low_seen;
		!battery_detect_two ##1 !battery_detect_two ##1 !battery_detect_two;
	endsequence

	// battery pin reaches the second stage no later than three edges
	a_sync_latency: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_07
		s_pin_low_seen |=> !sync_q[2])
		else $error("synchroniser latency wrong");

	// sense pin takes the same two-stage path
	a_sense_sync_latency: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_07
		s_sense_low_seen |=> !sync_q[0])
		else $error("sense pin synchroniser latency wrong");

	// a settled pin level shows in the interface status
	a_iface_latency: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_06
		s_batt_two_low_seen |=> !iface_status[3])
		else $error("interface status late for second battery pin");

	// a change bit stays until software clears it
	a_change_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_02
		(change_status[EV_DETECT] && !change_clear[EV_DETECT]) |=> change_status[EV_DETECT])
		else $error("change bit lost without clear");

	// an enabled detect change is recorded, even against a clear
	a_change_sets: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_02
		(events[EV_DETECT] && change_enable[EV_DETECT]) |=> change_status[EV_DETECT])
		else $error("enabled change not recorded");

	// with its enable low a clean bit stays clean
	a_change_masked: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_02
		(!change_status[EV_BATT_WEAK] && !change_enable[EV_BATT_WEAK]) |=> !change_status[EV_BATT_WEAK])
		else $error("masked change recorded");

	// a clear with no enabled event empties the bit
	a_change_cleared: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_02
		(change_clear[EV_BATT_DEAD] && !change_enable[EV_BATT_DEAD]) |=> !change_status[EV_BATT_DEAD])
		else $error("change bit survived its clear");

	// interrupt is the or of status bits under the enables of the previous edge
	a_irq_gated: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_02
		change_irq == |(change_status & $past(change_enable)))
		else $error("interrupt does not match enabled status");

	// an enabled status change of an io card is recorded
	a_card_status_change_sets: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_03
		(events[EV_STSC] && change_enable[EV_STSC]) |=> change_status[EV_STSC])
		else $error("status change not recorded");

	// the alert only rises for an io card with its pin low
	a_alert_io_only: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_03
		system_alert |-> ($past(io_card_mode) && !$past(sync_q[2])))
		else $error("alert outside io mode");

	// an io card pulling the pin low shows a ring
	a_ring_follows: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_04
		($past(io_card_mode) && !$past(sync_q[2])) |-> ring_indicate)
		else $error("ring not indicated");

	// no ring is shown for a memory card
	a_ring_memory_off: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_04
		!$past(io_card_mode) |-> !ring_indicate)
		else $error("ring shown for memory card");

	// the ring drops once the pin is back high
	a_ring_clears: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_04
		$past(sync_q[2]) |-> !ring_indicate)
		else $error("ring held with pin high");

	// interface status is the third stage of the pin chain
	a_iface_levels: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_06
		iface_status == $past(sync_q))
		else $error("interface status not pin levels");

endmodule : card_socket_status_sense

// ---- card_socket_status_sense_tb.sv ----
// self-checking bench for the socket status sense block
`timescale 1ns/1ps
module card_socket_status_sense_tb;
	import card_sense_pkg::*;
	logic       sys_clk, rst_n, inserted, io_card_mode, card_present, change_irq, system_alert, ring_indicate;
	logic       card_sense_one, card_sense_two, battery_detect_one, battery_detect_two;
	logic [1:0] batt_pins, battery_state;
	logic [3:0] change_enable, change_clear, iface_status, change_status;
	int         miscompares = 0, checks_done = 0, cycles = 0;
	card_model card (.inserted, .batt_pins, .card_sense_one, .card_sense_two, .battery_detect_one,
		.battery_detect_two);
	card_socket_status_sense dut (.sys_clk, .rst_n, .card_sense_one, .card_sense_two, .battery_detect_one,
		.battery_detect_two, .io_card_mode, .change_enable, .change_clear, .iface_status, .card_present,
		.battery_state, .change_status, .change_irq, .system_alert, .ring_indicate);
	task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic settle();
		repeat (6) @(negedge sys_clk);
	endtask : settle
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : give_verdict
	task automatic insert_card();
		change_enable = 4'hF;
		inserted = 1'h1;
		settle();
		chk("present", 4'h1, {3'h0, card_present});
		chk("pins", 4'hC, iface_status);
		chk("events", 4'h4, change_status);
		chk("irq", 4'h1, {3'h0, change_irq});
	endtask : insert_card
	task automatic battery_table();
		logic [1:0] exp [4] = '{BATT_GOOD, BATT_DEAD, BATT_WEAK, BATT_DEAD};
		for (int i = 0; i < 4; i++) begin
			batt_pins = 2'(3 - i);
			settle();
			chk("battery", {2'h0, exp[i]}, {2'h0, battery_state});
			chk("batt pins", {2'h0, batt_pins}, {2'h0, iface_status[3:2]});
		end
		chk("batt events", 4'h7, change_status);
	endtask : battery_table
	task automatic masked_events();
		change_enable = 4'h0;
		change_clear = 4'hF;
		@(negedge sys_clk);
		change_clear = 4'h0;
		batt_pins = 2'h3;
		settle();
		chk("masked", 4'h0, change_status);
		chk("masked irq", 4'h0, {3'h0, change_irq});
		change_enable = 4'h4;
		batt_pins = 2'h2;
		settle();
		chk("selective", 4'h0, change_status);
		inserted = 1'h0;
		settle();
		chk("removal", 4'h4, change_status);
		chk("removed", 4'h0, {3'h0, card_present});
		chk("idle pins", 4'hF, iface_status);
		change_enable = 4'h0;
		change_clear = 4'hF;
		batt_pins = 2'h3;
		inserted = 1'h1;
		@(negedge sys_clk);
		change_clear = 4'h0;
		settle();
		chk("reinserted", 4'h0, change_status);
	endtask : masked_events
	task automatic io_alert();
		io_card_mode = 1'h1;
		change_enable = 4'h8;
		batt_pins = 2'h2;
		settle();
		chk("alert on", 4'h3, {2'h0, system_alert, ring_indicate});
		batt_pins = 2'h3;
		settle();
		chk("alert off", 4'h0, {2'h0, system_alert, ring_indicate});
		chk("sts event", 4'h8, change_status & 4'h8);
	endtask : io_alert
	// free-running clock
	initial begin
		sys_clk = 1'h0;
		forever #5 sys_clk = ~sys_clk;
	end
	// hang guard, far above the ~80 cycles the run needs
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 500) begin
			miscompares++;
			give_verdict();
		end
	end
	// reset then scenarios
	initial begin
		{rst_n, inserted, io_card_mode} = 3'h0;
		batt_pins = 2'h3;
		change_enable = 4'h0;
		change_clear = 4'h0;
		repeat (12) @(negedge sys_clk);
		rst_n = 1'h1;
		insert_card();
		battery_table();
		masked_events();
		io_alert();
		give_verdict();
	end
endmodule : card_socket_status_sense_tb
